//--- hw/rxpfs_consts.svh
// Offsets, field positions, reset values and limits of the pause filter
`ifndef RXPFS_CONSTS_SVH
`define RXPFS_CONSTS_SVH

`define RXPFS_OFF_CTRL 8'h00
`define RXPFS_OFF_GMATCH 8'h04
`define RXPFS_OFF_PMATCH 8'h08
`define RXPFS_OFF_MCAST_LO 8'h0c
`define RXPFS_OFF_MCAST_HI 8'h10
`define RXPFS_OFF_UCAST_LO 8'h14
`define RXPFS_OFF_UCAST_HI 8'h18
`define RXPFS_OFF_SA_LO 8'h1c
`define RXPFS_OFF_SA_HI 8'h20
`define RXPFS_OFF_STATUS 8'h24

`define RXPFS_CTRL_G_EN 0
`define RXPFS_CTRL_G_MCAST 1
`define RXPFS_CTRL_G_UCAST 2
`define RXPFS_CTRL_G_SA 3
`define RXPFS_CTRL_G_ETYPE 4
`define RXPFS_CTRL_G_OPCODE 5
`define RXPFS_CTRL_P_EN 8
`define RXPFS_CTRL_P_MCAST 9
`define RXPFS_CTRL_P_UCAST 10
`define RXPFS_CTRL_P_SA 11
`define RXPFS_CTRL_P_ETYPE 12
`define RXPFS_CTRL_P_OPCODE 13
`define RXPFS_CTRL_CHECK_ACK 16
`define RXPFS_CTRL_MASK 32'h0001_3f3f

`define RXPFS_RST_CTRL 32'h0000_0000
`define RXPFS_RST_GMATCH 32'h0001_8808
`define RXPFS_RST_PMATCH 32'h0101_8808
`define RXPFS_RST_MCAST 48'h0180_c200_0001
`define RXPFS_RST_UCAST 48'h0000_0000_0000
`define RXPFS_RST_SA 48'h0000_0000_0000

`define RXPFS_STD_GOPCODE 16'h0001
`define RXPFS_STD_POPCODE 16'h0101
`define RXPFS_TPID_VLAN 16'h8100
`define RXPFS_MAX_LENGTH 16'h05dc
`define RXPFS_MIN_PAYLOAD 11'd46
`define RXPFS_HDR_PLAIN 11'd14
`define RXPFS_HDR_VLAN 11'd18
`define RXPFS_WORD_BYTES 11'd18
`define RXPFS_CNT_MAX 11'h7ff

`endif

//--- hw/rxpfs_pkg.sv
// Types shared by the pause filter modules
package rxpfs_pkg;

  typedef enum logic [0:0] {
    RXPFS_IDLE = 1'b0,
    RXPFS_FRAME = 1'b1
  } rxpfs_parse_state_t;

  typedef logic [8:0][15:0] rxpfs_words_t;

endpackage

//--- hw/rxpfs_frame_parse.sv
// Byte stream parser that captures the header and pause fields of a frame
`timescale 1ns/10ps
`include "rxpfs_consts.svh"
module rxpfs_frame_parse import rxpfs_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic rx_valid_in,
  input wire logic rx_sop_in,
  input wire logic rx_eop_in,
  input wire logic rx_fcs_ok_in,
  input wire logic [7:0] rx_data_in,
  output logic [47:0] da_out,
  output logic [47:0] sa_out,
  output logic [15:0] type_out,
  output logic [15:0] opcode_out,
  output logic vlan_out,
  output rxpfs_words_t word_out,
  output logic [10:0] payload_len_out,
  output logic done_out,
  output logic fcs_ok_out
);

  rxpfs_parse_state_t state, next_state;
  logic [10:0] cnt, next_cnt;
  logic [47:0] next_da, next_sa;
  logic [15:0] next_type, next_opcode;
  logic next_vlan, next_done, next_fcs_ok;
  logic [10:0] next_payload_len;
  logic [15:0] word_mem [0:8];
  logic [15:0] next_word_mem [0:8];
  logic [10:0] idx, hdr, pos, bytes;
  logic [3:0] wsel;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_da = da_out;
    next_sa = sa_out;
    next_type = type_out;
    next_opcode = opcode_out;
    next_vlan = vlan_out;
    next_done = 1'b0;
    next_fcs_ok = fcs_ok_out;
    next_payload_len = payload_len_out;
    next_word_mem = word_mem;
    idx = rx_sop_in ? 11'd0 : cnt;
    hdr = vlan_out ? `RXPFS_HDR_VLAN : `RXPFS_HDR_PLAIN;
    pos = idx - hdr;
    // Saturate on overlong frames, restart at each start of frame
    bytes = (idx == `RXPFS_CNT_MAX) ? idx : idx + 11'd1;
    wsel = 4'h0;
    if (rx_valid_in && (rx_sop_in || state == RXPFS_FRAME)) begin
      next_cnt = bytes;
      next_state = RXPFS_FRAME;
      if (rx_sop_in) begin
        next_vlan = 1'b0;
      end
      if (idx < 11'd6) begin
        next_da = {da_out[39:0], rx_data_in};
      end else if (idx < 11'd12) begin
        next_sa = {sa_out[39:0], rx_data_in};
      end else if (idx < hdr) begin
        // Tag bytes pass through, the inner type overwrites them
        next_type = {type_out[7:0], rx_data_in};
        if (idx == 11'd13 && !vlan_out &&
            {type_out[7:0], rx_data_in} == `RXPFS_TPID_VLAN) begin
          next_vlan = 1'b1;
        end
      end else if (pos < 11'd2) begin
        next_opcode = {opcode_out[7:0], rx_data_in};
      end else if (pos < 11'd2 + `RXPFS_WORD_BYTES) begin
        wsel = 4'((pos - 11'd2) >> 1);
        next_word_mem[wsel] = {word_mem[wsel][7:0], rx_data_in};
      end
      if (rx_eop_in) begin
        next_state = RXPFS_IDLE;
        next_done = 1'b1;
        next_fcs_ok = rx_fcs_ok_in;
        next_payload_len = (bytes > hdr) ? bytes - hdr : 11'd0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= RXPFS_IDLE;
      cnt <= 11'd0;
      da_out <= 48'h0;
      sa_out <= 48'h0;
      type_out <= 16'h0;
      opcode_out <= 16'h0;
      vlan_out <= 1'b0;
      done_out <= 1'b0;
      fcs_ok_out <= 1'b0;
      payload_len_out <= 11'd0;
      for (int i = 0; i < 9; i++) begin
        word_mem[i] <= 16'h0;
      end
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      da_out <= next_da;
      sa_out <= next_sa;
      type_out <= next_type;
      opcode_out <= next_opcode;
      vlan_out <= next_vlan;
      done_out <= next_done;
      fcs_ok_out <= next_fcs_ok;
      payload_len_out <= next_payload_len;
      word_mem <= next_word_mem;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 9; g++) begin : g_word
      assign word_out[g] = word_mem[g];
    end
  endgenerate

endmodule

//--- hw/rxpfs_top.sv
// Receive pause frame filter, pause report and packet statistics strobes
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`include "rxpfs_consts.svh"

// Notes on behaviour
// - Global pause needs multicast DA when enabled
// - Global pause accepts unicast DA when enabled
// - Global pause rejects mismatching SA when enabled
// - Global pause type must equal configured value
// - Global pause opcode must equal configured value
// - Priority pause recognised only while enabled
// - Priority pause needs multicast DA when enabled
// - Priority pause accepts unicast DA when enabled
// - Priority pause rejects mismatching SA when enabled
// - Priority pause type must equal configured value
// - Priority pause opcode must equal configured value
// - Strobes for good unicast, multicast, broadcast
// - Strobe for good VLAN tagged packets
// - Strobe for global pause with good FCS
// - Strobe for priority pause with good FCS
// - Strobe for length error with good FCS
// - Nine bit valid vector flags usable quanta
// - Global pause sets valid bit eight
// - Nine quanta outputs, entry eight is global
// - Global pause recognised only while enabled
// - Request bit held until pause processed
module rxpfs_top import rxpfs_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic rx_valid_in,
  input wire logic rx_sop_in,
  input wire logic rx_eop_in,
  input wire logic rx_fcs_ok_in,
  input wire logic [7:0] rx_data_in,
  input wire logic [8:0] rx_pause_ack_in,
  output logic stat_unicast_out,
  output logic stat_multicast_out,
  output logic stat_broadcast_out,
  output logic stat_vlan_out,
  output logic stat_global_pause_out,
  output logic stat_priority_pause_out,
  output logic stat_length_err_out,
  output logic [8:0] rx_pause_valid_out,
  output rxpfs_words_t rx_pause_time_entry_out,
  output logic [8:0] rx_pause_req_out
);

  // Register file
  logic [31:0] ctrl, next_ctrl;
  logic [31:0] gmatch, next_gmatch;
  logic [31:0] pmatch, next_pmatch;
  logic [47:0] mcast_addr, next_mcast_addr;
  logic [47:0] ucast_addr, next_ucast_addr;
  logic [47:0] src_addr, next_src_addr;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic [31:0] rd_mux;
  logic rd_err, wr_take;

  // Parser results
  logic [47:0] f_da, f_sa;
  logic [15:0] f_type, f_opcode;
  logic f_vlan, f_done, f_fcs_ok;
  rxpfs_words_t f_word;
  logic [10:0] f_len;

  // Qualification
  logic good, is_bcast, is_mcast, len_field, len_err;
  logic g_da_ok, g_sa_ok, g_type_ok, g_op_ok, g_hit;
  logic p_da_ok, p_sa_ok, p_type_ok, p_op_ok, p_hit;

  // Report and strobes
  logic [8:0] set_valid, next_valid, clr_req, next_req;
  rxpfs_words_t next_entry;
  logic next_uni, next_multi, next_bcast, next_vlan_stat;
  logic next_gstat, next_pstat, next_lenstat;

  rxpfs_frame_parse u_parse (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .rx_valid_in(rx_valid_in),
    .rx_sop_in(rx_sop_in),
    .rx_eop_in(rx_eop_in),
    .rx_fcs_ok_in(rx_fcs_ok_in),
    .rx_data_in(rx_data_in),
    .da_out(f_da),
    .sa_out(f_sa),
    .type_out(f_type),
    .opcode_out(f_opcode),
    .vlan_out(f_vlan),
    .word_out(f_word),
    .payload_len_out(f_len),
    .done_out(f_done),
    .fcs_ok_out(f_fcs_ok)
  );

  // APB read decode
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    case (paddr_in)
      `RXPFS_OFF_CTRL: rd_mux = ctrl;
      `RXPFS_OFF_GMATCH: rd_mux = gmatch;
      `RXPFS_OFF_PMATCH: rd_mux = pmatch;
      `RXPFS_OFF_MCAST_LO: rd_mux = mcast_addr[31:0];
      `RXPFS_OFF_MCAST_HI: rd_mux = {16'h0, mcast_addr[47:32]};
      `RXPFS_OFF_UCAST_LO: rd_mux = ucast_addr[31:0];
      `RXPFS_OFF_UCAST_HI: rd_mux = {16'h0, ucast_addr[47:32]};
      `RXPFS_OFF_SA_LO: rd_mux = src_addr[31:0];
      `RXPFS_OFF_SA_HI: rd_mux = {16'h0, src_addr[47:32]};
      `RXPFS_OFF_STATUS: rd_mux = {7'h0, rx_pause_valid_out,
                                   7'h0, rx_pause_req_out};
      default: rd_err = 1'b1;
    endcase
  end

  // APB handshake, one wait state, answer in second access cycle
  always_comb begin
    next_pready = psel_in && penable_in && !pready_out;
    next_prdata = prdata_out;
    next_pslverr = 1'b0;
    if (psel_in && penable_in && !pready_out) begin
      next_prdata = pwrite_in ? 32'h0 : rd_mux;
      next_pslverr = rd_err;
    end
  end

  assign wr_take = psel_in && penable_in && pready_out && pwrite_in &&
                   !pslverr_out;

  // APB writes
  always_comb begin
    next_ctrl = ctrl;
    next_gmatch = gmatch;
    next_pmatch = pmatch;
    next_mcast_addr = mcast_addr;
    next_ucast_addr = ucast_addr;
    next_src_addr = src_addr;
    if (wr_take) begin
      case (paddr_in)
        `RXPFS_OFF_CTRL: next_ctrl = pwdata_in & `RXPFS_CTRL_MASK;
        `RXPFS_OFF_GMATCH: next_gmatch = pwdata_in;
        `RXPFS_OFF_PMATCH: next_pmatch = pwdata_in;
        `RXPFS_OFF_MCAST_LO: next_mcast_addr[31:0] = pwdata_in;
        `RXPFS_OFF_MCAST_HI: next_mcast_addr[47:32] = pwdata_in[15:0];
        `RXPFS_OFF_UCAST_LO: next_ucast_addr[31:0] = pwdata_in;
        `RXPFS_OFF_UCAST_HI: next_ucast_addr[47:32] = pwdata_in[15:0];
        `RXPFS_OFF_SA_LO: next_src_addr[31:0] = pwdata_in;
        `RXPFS_OFF_SA_HI: next_src_addr[47:32] = pwdata_in[15:0];
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl <= `RXPFS_RST_CTRL;
      gmatch <= `RXPFS_RST_GMATCH;
      pmatch <= `RXPFS_RST_PMATCH;
      mcast_addr <= `RXPFS_RST_MCAST;
      ucast_addr <= `RXPFS_RST_UCAST;
      src_addr <= `RXPFS_RST_SA;
    end else begin
      ctrl <= next_ctrl;
      gmatch <= next_gmatch;
      pmatch <= next_pmatch;
      mcast_addr <= next_mcast_addr;
      ucast_addr <= next_ucast_addr;
      src_addr <= next_src_addr;
    end
  end

  // Bus answer, ready and error stand for one cycle, read data holds until the next access
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h0;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
    end
  end

  // Frame class
  assign good = f_done && f_fcs_ok;
  assign is_bcast = &f_da;
  assign is_mcast = f_da[40] && !is_bcast;
  assign len_field = (f_type <= `RXPFS_MAX_LENGTH);
  // Padded short frames carry a length below the minimum payload
  assign len_err = len_field && (f_type[10:0] != f_len) &&
                   !(f_len == `RXPFS_MIN_PAYLOAD &&
                     f_type[10:0] < `RXPFS_MIN_PAYLOAD);

  // Global pause qualification
  assign g_da_ok = !(ctrl[`RXPFS_CTRL_G_MCAST] || ctrl[`RXPFS_CTRL_G_UCAST])
                   || (ctrl[`RXPFS_CTRL_G_MCAST] && f_da == mcast_addr)
                   || (ctrl[`RXPFS_CTRL_G_UCAST] && f_da == ucast_addr);
  assign g_sa_ok = !ctrl[`RXPFS_CTRL_G_SA] || f_sa == src_addr;
  assign g_type_ok = !ctrl[`RXPFS_CTRL_G_ETYPE] ||
                     f_type == gmatch[15:0];
  assign g_op_ok = ctrl[`RXPFS_CTRL_G_OPCODE] ?
                   f_opcode == gmatch[31:16] :
                   f_opcode == `RXPFS_STD_GOPCODE;
  assign g_hit = good && ctrl[`RXPFS_CTRL_G_EN] &&
                 g_da_ok && g_sa_ok && g_type_ok && g_op_ok;

  // Priority pause qualification
  assign p_da_ok = !(ctrl[`RXPFS_CTRL_P_MCAST] || ctrl[`RXPFS_CTRL_P_UCAST])
                   || (ctrl[`RXPFS_CTRL_P_MCAST] && f_da == mcast_addr)
                   || (ctrl[`RXPFS_CTRL_P_UCAST] && f_da == ucast_addr);
  assign p_sa_ok = !ctrl[`RXPFS_CTRL_P_SA] || f_sa == src_addr;
  assign p_type_ok = !ctrl[`RXPFS_CTRL_P_ETYPE] ||
                     f_type == pmatch[15:0];
  assign p_op_ok = ctrl[`RXPFS_CTRL_P_OPCODE] ?
                   f_opcode == pmatch[31:16] :
                   f_opcode == `RXPFS_STD_POPCODE;
  assign p_hit = good && ctrl[`RXPFS_CTRL_P_EN] && !g_hit &&
                 p_da_ok && p_sa_ok && p_type_ok && p_op_ok;

  // Pause report and request, one slice per entry; entry 8 is global
  genvar e;
  generate
    for (e = 0; e < 9; e++) begin : g_entry
      logic hit, take;
      logic [15:0] quanta;
      if (e == 8) begin : g_global
        assign hit = g_hit;
        assign take = 1'b1;
        assign quanta = f_word[0];
      end else begin : g_prio
        assign hit = p_hit;
        // Word 0 of a priority frame enables the classes
        assign take = f_word[0][e];
        assign quanta = f_word[e + 1];
      end
      assign set_valid[e] = hit && take;
      // Quanta stand until the next accepted pause of this entry
      assign next_entry[e] = set_valid[e] ? quanta :
                             rx_pause_time_entry_out[e];
      // Acknowledge is only consulted when waiting for it
      assign clr_req[e] = ctrl[`RXPFS_CTRL_CHECK_ACK] ?
                          rx_pause_ack_in[e] :
                          rx_pause_req_out[e];
      // A new pause wins over a clear in the same cycle
      assign next_req[e] = set_valid[e] ||
                           (rx_pause_req_out[e] && !clr_req[e]);
    end
  endgenerate

  always_comb begin
    next_valid = set_valid;
  end

  // Statistics strobes, one cycle after the frame ends
  always_comb begin
    next_uni = good && !f_da[40];
    next_multi = good && is_mcast;
    next_bcast = good && is_bcast;
    next_vlan_stat = good && f_vlan;
    next_gstat = g_hit;
    next_pstat = p_hit;
    next_lenstat = good && len_err;
  end

  // Pause report registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_pause_valid_out <= 9'h0;
      rx_pause_time_entry_out <= '0;
      rx_pause_req_out <= 9'h0;
    end else begin
      rx_pause_valid_out <= next_valid;
      rx_pause_time_entry_out <= next_entry;
      rx_pause_req_out <= next_req;
    end
  end

  // Statistics strobe registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stat_unicast_out <= 1'b0;
      stat_multicast_out <= 1'b0;
      stat_broadcast_out <= 1'b0;
      stat_vlan_out <= 1'b0;
      stat_global_pause_out <= 1'b0;
      stat_priority_pause_out <= 1'b0;
      stat_length_err_out <= 1'b0;
    end else begin
      // Done is a single cycle pulse, so each strobe is too
      stat_unicast_out <= next_uni;
      stat_multicast_out <= next_multi;
      stat_broadcast_out <= next_bcast;
      stat_vlan_out <= next_vlan_stat;
      stat_global_pause_out <= next_gstat;
      stat_priority_pause_out <= next_pstat;
      stat_length_err_out <= next_lenstat;
    end
  end

endmodule

//--- verification/rxpfs_chk.sv
// Port checker for the pause filter
`timescale 1ns/10ps
module rxpfs_chk import rxpfs_pkg::*; (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic stat_unicast_out,
  input wire logic stat_multicast_out,
  input wire logic stat_broadcast_out,
  input wire logic stat_global_pause_out,
  input wire logic stat_priority_pause_out,
  input wire logic stat_length_err_out,
  input wire logic [8:0] rx_pause_valid_out,
  input wire rxpfs_words_t rx_pause_time_entry_out,
  input wire logic [8:0] rx_pause_req_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  strobe_pulse_a: assert property (stat_global_pause_out ||
    stat_priority_pause_out || stat_length_err_out |=> !(stat_global_pause_out
    || stat_priority_pause_out || stat_length_err_out)) else $error("long");
  gvalid_req_a: assert property (rx_pause_valid_out[8] |->
    stat_global_pause_out && rx_pause_req_out[8]) else $error("no req");
  global_bit_a: assert property (stat_global_pause_out |->
    rx_pause_valid_out == 9'h100) else $error("valid bit");
  kind_excl_a: assert property (stat_priority_pause_out |->
    !stat_global_pause_out && !rx_pause_valid_out[8]) else $error("kind");
  quanta_hold_a: assert property (rx_pause_valid_out == 9'h000 |->
    $stable(rx_pause_time_entry_out)) else $error("quanta moved");
  valid_pulse_a: assert property (|rx_pause_valid_out |=>
    rx_pause_valid_out == 9'h000) else $error("valid long");
  cast_excl_a: assert property (stat_unicast_out |->
    !(stat_multicast_out || stat_broadcast_out)) else $error("cast");
  apb_wait_a: assert property (psel_in && !penable_in |->
    ##2 pready_out) else $error("ready late");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error alone");
endmodule

bind rxpfs_top rxpfs_chk chk (.mclk_in, .rstn_in, .psel_in, .penable_in,
  .pready_out, .pslverr_out, .stat_unicast_out, .stat_multicast_out,
  .stat_broadcast_out, .stat_global_pause_out, .stat_priority_pause_out,
  .stat_length_err_out, .rx_pause_valid_out, .rx_pause_time_entry_out,
  .rx_pause_req_out);

//--- verification/rxpfs_user_model.sv
// Pause consumer that acknowledges requests after a delay
`timescale 1ns/10ps
module rxpfs_user_model #(parameter int DLY = 6) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [8:0] req_in,
  output logic [8:0] ack_out
);
  logic [3:0] cnt, next_cnt;
  logic [8:0] next_ack;
  always_comb begin
    next_cnt = 4'h0;
    next_ack = 9'h000;
    if (req_in != 9'h000 && ack_out == 9'h000) begin
      next_cnt = cnt + 4'h1;
      if (cnt == 4'(DLY)) begin
        next_ack = req_in;
      end
    end
  end
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt <= 4'h0;
      ack_out <= 9'h000;
    end else begin
      cnt <= next_cnt;
      ack_out <= next_ack;
    end
  end
endmodule

//--- verification/rxpfs_tb_top.sv
// Self-checking bench for the receive pause filter
`timescale 1ns/10ps
`include "rxpfs_consts.svh"
module rxpfs_tb_top import rxpfs_pkg::*;;
  logic mclk_in = 1'b0, rstn_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, rx_data_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic rx_valid_in = 1'b0, rx_sop_in = 1'b0, rx_eop_in = 1'b0;
  logic rx_fcs_ok_in = 1'b0, pready_out, pslverr_out;
  logic stat_unicast_out, stat_multicast_out, stat_broadcast_out;
  logic stat_vlan_out, stat_global_pause_out, stat_priority_pause_out;
  logic stat_length_err_out;
  logic [8:0] rx_pause_ack_in, rx_pause_valid_out, rq, vsn = 9'h0;
  rxpfs_words_t ent;
  logic [6:0] seen = 7'h0;
  int bad_count = 0;
  int checks = 0;
  localparam logic [47:0] MC = `RXPFS_RST_MCAST;
  localparam logic [47:0] UC = 48'h0000_0a0b_0c0d;
  localparam logic [7:0] CT = `RXPFS_OFF_CTRL;
  always #20 mclk_in = ~mclk_in;
  rxpfs_top dut (.mclk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .rx_valid_in, .rx_sop_in, .rx_eop_in, .rx_fcs_ok_in, .rx_data_in,
    .rx_pause_ack_in, .stat_unicast_out, .stat_multicast_out,
    .stat_broadcast_out, .stat_vlan_out, .stat_global_pause_out,
    .stat_priority_pause_out, .stat_length_err_out, .rx_pause_valid_out,
    .rx_pause_time_entry_out(ent), .rx_pause_req_out(rq));
  rxpfs_user_model #(.DLY(6)) usr (.mclk_in, .rstn_in, .req_in(rq),
    .ack_out(rx_pause_ack_in));
  always @(posedge mclk_in) begin
    seen <= seen | {stat_unicast_out, stat_multicast_out, stat_broadcast_out,
      stat_vlan_out, stat_global_pause_out, stat_priority_pause_out,
      stat_length_err_out};
    vsn <= vsn | rx_pause_valid_out;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (pready_out !== 1'b1) bad_count++;
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic frame(input logic [47:0] da, input logic [47:0] sa,
      input logic [15:0] ty, input logic [15:0] op, input logic [15:0] q0,
      input logic fcs);
    logic [7:0] fb [60];
    for (int i = 0; i < 60; i++) fb[i] = 8'h00;
    for (int i = 0; i < 6; i++) begin
      fb[i] = da[47 - 8 * i -: 8];
      fb[6 + i] = sa[47 - 8 * i -: 8];
    end
    {fb[12], fb[13], fb[14], fb[15], fb[16], fb[17]} = {ty, op, q0};
    for (int k = 1; k < 9; k++) begin
      fb[16 + 2 * k] = 8'(k);
      fb[17 + 2 * k] = 8'(k);
    end
    @(negedge mclk_in);
    seen = 7'h0;
    vsn = 9'h0;
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk_in);
      rx_valid_in <= 1'b1;
      rx_sop_in <= (i == 0);
      rx_eop_in <= (i == 59);
      rx_fcs_ok_in <= fcs;
      rx_data_in <= fb[i];
    end
    @(posedge mclk_in);
    rx_valid_in <= 1'b0;
    rx_eop_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask
  task automatic row(input logic [31:0] c, input logic [47:0] da,
      input logic bsa, input logic [15:0] ty, input logic [15:0] op,
      input logic [1:0] x);
    wr(CT, c);
    frame(da, bsa ? 48'h0200_0000_0007 : 48'h0, ty, op, 16'h00ff, 1'b1);
    chk({30'h0, seen[2:1]}, {30'h0, x});
  endtask
  task automatic t_regs;
    rd(CT, `RXPFS_RST_CTRL, 1'b0);
    rd(`RXPFS_OFF_GMATCH, `RXPFS_RST_GMATCH, 1'b0);
    rd(`RXPFS_OFF_PMATCH, `RXPFS_RST_PMATCH, 1'b0);
    rd(`RXPFS_OFF_MCAST_LO, 32'hc200_0001, 1'b0);
    rd(8'h28, 32'h0, 1'b1);
    wr(CT, 32'hffff_ffff);
    rd(CT, `RXPFS_CTRL_MASK, 1'b0);
  endtask
  task automatic t_rows;
    wr(`RXPFS_OFF_UCAST_LO, 32'h0a0b_0c0d);
    row(32'h03, MC, 1'b0, 16'h8808, 16'h0001, 2'b10);
    row(32'h03, UC, 1'b0, 16'h8808, 16'h0001, 2'b00);
    row(32'h05, UC, 1'b0, 16'h8808, 16'h0001, 2'b10);
    row(32'h05, MC, 1'b0, 16'h8808, 16'h0001, 2'b00);
    row(32'h09, MC, 1'b1, 16'h8808, 16'h0001, 2'b00);
    row(32'h11, MC, 1'b0, 16'h8809, 16'h0001, 2'b00);
    row(32'h00, MC, 1'b0, 16'h8808, 16'h0001, 2'b00);
    row(32'h100, MC, 1'b0, 16'h8808, 16'h0101, 2'b01);
    row(32'h000, MC, 1'b0, 16'h8808, 16'h0101, 2'b00);
    row(32'h300, UC, 1'b0, 16'h8808, 16'h0101, 2'b00);
    row(32'h500, UC, 1'b0, 16'h8808, 16'h0101, 2'b01);
    row(32'h900, MC, 1'b1, 16'h8808, 16'h0101, 2'b00);
    row(32'h1100, MC, 1'b0, 16'h8809, 16'h0101, 2'b00);
    wr(`RXPFS_OFF_GMATCH, 32'h0003_8808);
    wr(`RXPFS_OFF_PMATCH, 32'h0103_8808);
    row(32'h21, MC, 1'b0, 16'h8808, 16'h0001, 2'b00);
    row(32'h2100, MC, 1'b0, 16'h8808, 16'h0101, 2'b00);
  endtask
  task automatic t_pause;
    wr(CT, 32'h1);
    frame(MC, 48'h0, 16'h8808, 16'h0001, 16'h1234, 1'b1);
    chk({23'h0, vsn}, 32'h100);
    chk({16'h0, ent[8]}, 32'h1234);
    chk({25'h0, seen}, 32'h24);
    chk({23'h0, rq}, 32'h0);
    frame(MC, 48'h0, 16'h8808, 16'h0001, 16'h1234, 1'b0);
    chk({25'h0, seen}, 32'h0);
    wr(CT, 32'h100);
    frame(MC, 48'h0, 16'h8808, 16'h0101, 16'h0005, 1'b1);
    chk({23'h0, vsn}, 32'h005);
    chk({16'h0, ent[0]}, 32'h0101);
    chk({16'h0, ent[2]}, 32'h0303);
    chk({16'h0, ent[8]}, 32'h1234);
    chk({25'h0, seen}, 32'h22);
  endtask
  task automatic t_stats;
    wr(CT, 32'h0);
    frame('1, UC, 16'h0800, 16'h0, 16'h0, 1'b1);
    chk({25'h0, seen}, 32'h10);
    frame(UC, MC, 16'h0800, 16'h0, 16'h0, 1'b1);
    chk({25'h0, seen}, 32'h40);
    frame(UC, MC, 16'h8100, 16'h0, 16'h0800, 1'b1);
    chk({25'h0, seen}, 32'h48);
    frame(UC, MC, 16'h0100, 16'h0, 16'h0, 1'b1);
    chk({25'h0, seen}, 32'h41);
  endtask
  task automatic t_ack;
    wr(CT, 32'h1_0001);
    frame(MC, 48'h0, 16'h8808, 16'h0001, 16'h0042, 1'b1);
    chk({23'h0, rq}, 32'h100);
    rd(`RXPFS_OFF_STATUS, 32'h0000_0100, 1'b0);
    repeat (15) @(posedge mclk_in);
    chk({23'h0, rq}, 32'h0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    t_regs;
    t_rows;
    t_pause;
    t_stats;
    t_ack;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    report_and_stop;
  end
endmodule
